/* src/rtc_calendar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"

module rtc_calendar #(
    parameter int PRESC = `RTC_PRESC_DIV,
    parameter int SW_W = `RTC_SW_W
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // crystal oscillator output, sampled here
    input wire logic xtal_in,
    // axi4-lite write address
    input wire logic [`RTC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [`RTC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt and wakeup
    output logic irq,
    output logic wake_req
);

    localparam int PW = $clog2(PRESC);

    // refuse settings the counters cannot serve
    generate
        if (PRESC < 2 || SW_W < 1 || SW_W > 32)
        begin : g_bad
            $error("rtc_calendar: bad PRESC or SW_W");
        end
    endgenerate

    // byte-lane merge of a write into a stored word
    function automatic rtc_pkg::word_t merge(
        input rtc_pkg::word_t old_w,
        input rtc_pkg::word_t new_w,
        input logic [3:0] strb
    );
        rtc_pkg::word_t res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return res;
    endfunction

    // pack four fields into the time word layout
    function automatic rtc_pkg::word_t pack(
        input rtc_pkg::sec_t s,
        input rtc_pkg::min_t m,
        input rtc_pkg::hour_t h,
        input rtc_pkg::day_t d
    );
        return {d, h, m, s};
    endfunction

    // crystal synchroniser and edge detector
    logic xs1, xs2, xs3; // xs1 read only by xs2
    logic [PW-1:0] presc; // crystal edges in current second
    // time counters
    rtc_pkg::sec_t sec;
    rtc_pkg::min_t min;
    rtc_pkg::hour_t hour;
    rtc_pkg::day_t day;
    // alarm words and stopwatch
    rtc_pkg::word_t alarm0, alarm1;
    logic [SW_W-1:0] sw_cnt; // stopwatch count
    logic sw_en; // stopwatch running
    // interrupt state
    rtc_pkg::event_t status; // sticky event flags
    rtc_pkg::event_t mask; // event enables
    // write channel holding state
    logic aw_got, w_got;
    logic [`RTC_ADDR_W-1:0] aw_q;
    rtc_pkg::word_t wd_q;
    logic [3:0] ws_q;

    // crystal rising edge and one-second tick
    wire xedge = xs2 & ~xs3;
    wire tick = xedge && (presc == PW'(PRESC - 1)); // RQ2

    // carry chain of the counters
    wire sec_wrap = (sec == `RTC_SEC_MAX);
    wire min_wrap = sec_wrap && (min == `RTC_MIN_MAX);
    wire hour_wrap = min_wrap && (hour == `RTC_HOUR_MAX);

    // counter values after this tick
    wire rtc_pkg::sec_t nsec = sec_wrap ? '0 : sec + 6'h01; // RQ3
    wire rtc_pkg::min_t nmin = !sec_wrap ? min :
        (min == `RTC_MIN_MAX) ? '0 : min + 6'h01; // RQ4
    wire rtc_pkg::hour_t nhour = !min_wrap ? hour :
        (hour == `RTC_HOUR_MAX) ? '0 : hour + 5'h01; // RQ4
    wire rtc_pkg::day_t nday = hour_wrap ? day + 15'h0001 : day; // RQ4
    wire rtc_pkg::word_t ntime = pack(nsec, nmin, nhour, nday);
    wire rtc_pkg::word_t cur_time = pack(sec, min, hour, day);

    // bus handshakes
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire ar_hs = arvalid & arready;
    wire do_write = aw_got & w_got & ~bvalid;

    // write decode
    wire wr_time = do_write && (aw_q == `RTC_OFF_TIME);
    wire wr_a0 = do_write && (aw_q == `RTC_OFF_ALARM0);
    wire wr_a1 = do_write && (aw_q == `RTC_OFF_ALARM1);
    wire wr_sw = do_write && (aw_q == `RTC_OFF_SWATCH);
    wire wr_ctrl = do_write && (aw_q == `RTC_OFF_CTRL);
    wire wr_mask = do_write && (aw_q == `RTC_OFF_MASK);
    wire wr_ok = wr_time | wr_a0 | wr_a1 | wr_sw | wr_ctrl | wr_mask |
        (aw_q == `RTC_OFF_STATUS);

    // merged write words
    wire rtc_pkg::word_t tw = merge(cur_time, wd_q, ws_q);
    wire rtc_pkg::word_t sww = merge(32'(sw_cnt), wd_q, ws_q);
    wire rtc_pkg::word_t cw = merge({31'h0, sw_en}, wd_q, ws_q);
    wire rtc_pkg::word_t mw = merge({25'h0, mask}, wd_q, ws_q);

    // alarm compares against the time after the tick
    wire tmatch = (ntime[`RTC_DAY_LSB-1:0] ==
        alarm0[`RTC_DAY_LSB-1:0]); // RQ6
    wire a0_hit = tick && !wr_time && tmatch; // RQ5
    wire a1_hit = tick && !wr_time && (ntime == alarm1); // RQ6
    wire sw_ev = tick && sw_en && (sw_cnt == '0); // RQ8

    // all events of this cycle
    wire rtc_pkg::event_t ev = {sw_ev, a1_hit, a0_hit,
        tick & hour_wrap, tick & min_wrap,
        tick & sec_wrap, tick}; // RQ9

    // status read clears, a new event in that cycle still sets
    wire st_clr = ar_hs && (araddr == `RTC_OFF_STATUS);
    wire rtc_pkg::event_t next_status =
        (st_clr ? '0 : status) | ev; // RQ11

    // read mux
    wire rtc_pkg::word_t rd_word =
        (araddr == `RTC_OFF_TIME) ? cur_time :
        (araddr == `RTC_OFF_ALARM0) ? alarm0 :
        (araddr == `RTC_OFF_ALARM1) ? alarm1 :
        (araddr == `RTC_OFF_SWATCH) ? 32'(sw_cnt) :
        (araddr == `RTC_OFF_CTRL) ? {31'h0, sw_en} :
        (araddr == `RTC_OFF_STATUS) ? {25'h0, status} :
        (araddr == `RTC_OFF_MASK) ? {25'h0, mask} : '0;
    wire rd_ok = (araddr == `RTC_OFF_TIME) ||
        (araddr == `RTC_OFF_ALARM0) || (araddr == `RTC_OFF_ALARM1) ||
        (araddr == `RTC_OFF_SWATCH) || (araddr == `RTC_OFF_CTRL) ||
        (araddr == `RTC_OFF_STATUS) || (araddr == `RTC_OFF_MASK);

    // next channel states for the registered readies
    wire next_aw_got = (aw_got | aw_hs) & ~do_write;
    wire next_w_got = (w_got | w_hs) & ~do_write;
    wire next_bvalid = do_write | (bvalid & ~bready);
    wire next_rvalid = ar_hs | (rvalid & ~rready);

    // crystal sampling: two flops then one for edge detection
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            xs1 <= 1'b0;
            xs2 <= 1'b0;
            xs3 <= 1'b0;
        end
        else
        begin
            xs1 <= xtal_in; // RQ1
            xs2 <= xs1;
            xs3 <= xs2;
        end
    end

    // prescaler, restarted when time is written
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            presc <= '0;
        else if (wr_time || tick)
            presc <= '0;
        else if (xedge)
            presc <= presc + PW'(1); // RQ2
    end

    // time counters, a software write wins over a tick
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sec <= '0;
            min <= '0;
            hour <= '0;
            day <= '0;
        end
        else if (wr_time)
        begin
            sec <= tw[`RTC_SEC_LSB +: 6];
            min <= tw[`RTC_MIN_LSB +: 6];
            hour <= tw[`RTC_HOUR_LSB +: 5];
            day <= tw[`RTC_DAY_LSB +: 15];
        end
        else if (tick)
        begin
            sec <= nsec; // RQ3
            min <= nmin; // RQ4
            hour <= nhour; // RQ4
            day <= nday; // RQ4
        end
    end

    // alarm words
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            alarm0 <= '0;
            alarm1 <= '0;
        end
        else
        begin
            if (wr_a0)
                alarm0 <= merge(alarm0, wd_q, ws_q);
            if (wr_a1)
                alarm1 <= merge(alarm1, wd_q, ws_q);
        end
    end

    // stopwatch: load, count down, stop on underflow
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sw_cnt <= '0;
            sw_en <= 1'b0;
        end
        else
        begin
            if (wr_sw)
                sw_cnt <= sww[SW_W-1:0]; // RQ7
            else if (tick && sw_en && sw_cnt != '0)
                sw_cnt <= sw_cnt - SW_W'(1); // RQ7
            if (wr_ctrl)
                sw_en <= cw[`RTC_CTRL_SW_EN];
            else if (sw_ev)
                sw_en <= 1'b0; // RQ8
        end
    end

    // sticky status, mask, interrupt and wakeup
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            status <= next_status; // RQ11
            if (wr_mask)
                mask <= mw[6:0];
            irq <= |(status & mask); // RQ5
            wake_req <= |(ev & mask); // RQ10
        end
    end

    // write address and data capture, either order
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            if (aw_hs)
                aw_q <= awaddr;
            if (w_hs)
            begin
                wd_q <= wdata;
                ws_q <= wstrb;
            end
        end
    end

    // write response and registered readies
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RTC_RESP_OKAY;
        end
        else
        begin
            awready <= ~next_aw_got & ~next_bvalid;
            wready <= ~next_w_got & ~next_bvalid;
            bvalid <= next_bvalid;
            if (do_write)
                bresp <= wr_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
        end
    end

    // read channel
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RTC_RESP_OKAY;
        end
        else
        begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_hs)
            begin
                rdata <= rd_word;
                rresp <= rd_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
            end
        end
    end

endmodule

`default_nettype wire

/* src/rtc_defines.svh */
// Notes on behaviour
// RQ1: timekeeping runs from 32.768 kHz crystal input
// RQ2: prescaler divides crystal to one-second tick
// RQ3: seconds, minutes, hours, 32768-day counters
// RQ4: each wrap carries into next counter
// RQ5: enabled alarm interrupts on matching tick
// RQ6: alarm0 time of day, alarm1 day+time
// RQ7: stopwatch loaded by software, decrements per tick
// RQ8: stopwatch underflow raises interrupt when enabled
// RQ9: selectable second/minute/hour/day periodic interrupts
// RQ10: enabled events raise a wakeup request
// RQ11: events latch sticky until software clears
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// crystal rate in Hz and the tick rate
`define RTC_XTAL_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_PRESC_DIV (`RTC_XTAL_HZ / `RTC_TICK_HZ)
`define RTC_SW_W 16

// register byte offsets
`define RTC_ADDR_W 5
`define RTC_OFF_TIME 5'h00
`define RTC_OFF_ALARM0 5'h04
`define RTC_OFF_ALARM1 5'h08
`define RTC_OFF_SWATCH 5'h0C
`define RTC_OFF_CTRL 5'h10
`define RTC_OFF_STATUS 5'h14
`define RTC_OFF_MASK 5'h18

// time word layout
`define RTC_SEC_LSB 0
`define RTC_MIN_LSB 6
`define RTC_HOUR_LSB 12
`define RTC_DAY_LSB 17
`define RTC_SEC_MAX 6'h3B
`define RTC_MIN_MAX 6'h3B
`define RTC_HOUR_MAX 5'h17

// control and event bits
`define RTC_CTRL_SW_EN 0
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALARM0 4
`define RTC_EV_ALARM1 5
`define RTC_EV_SWATCH 6

// bus answers
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

/* src/rtc_pkg.sv */
package rtc_pkg;
    // counter field types
    typedef logic [5:0] sec_t;
    typedef logic [5:0] min_t;
    typedef logic [4:0] hour_t;
    typedef logic [14:0] day_t;
    // event vector, one bit per event source
    typedef logic [6:0] event_t;
    // bus data word
    typedef logic [31:0] word_t;
endpackage

/* tb/rtc_calendar_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // events
    input wire logic irq,
    input wire logic wake_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    AST_B_DONE: assert property (
        bvalid && bready |=> !bvalid)
        else $error("write answer held too long");
    AST_W_ANSWER: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write answer late");
    AST_AW_BLOCK: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    AST_R_ANSWER: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed early");
    AST_R_DONE: assert property (
        rvalid && rready |=> !rvalid)
        else $error("read answer held too long");
    AST_AR_BLOCK: assert property (
        rvalid |-> !arready)
        else $error("read taken while answering");
    AST_WAKE_PULSE: assert property (
        wake_req |=> !wake_req)
        else $error("wake request longer than a cycle");
    AST_WAKE_IRQ: assert property (
        wake_req |-> ##[0:2] irq)
        else $error("wake request without interrupt");
    // main scenarios
    cover property (wake_req);
    cover property ($rose(irq));
    cover property (rvalid && rresp == 2'h2);
endmodule
bind rtc_calendar rtc_calendar_asserts chk (.*);
`default_nettype wire

/* tb/test_rtc_calendar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module test_rtc_calendar;
    // stimulus
    logic ref_clk = 1'h0, nrst = 1'h0, xtal_in = 1'h0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    // design answers
    wire logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    // crystal divider, counters and model state
    logic [2:0] xcnt = 3'h0;
    int err_count = 0, checked = 0, cyc = 0;
    int s, m, h, d, st;
    // model copies of the alarm words, reset value zero
    logic [31:0] a0 = 32'h0, a1 = 32'h0;
    rtc_calendar #(.PRESC(8)) dut (.*);
    // 20 MHz system clock
    initial forever #25 ref_clk = ~ref_clk;
    // crystal at one eighth of the clock, plus the hang limit
    always @(posedge ref_clk)
    begin
        xcnt <= xcnt + 3'h1;
        xtal_in <= xcnt[2];
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [4:0] a, input logic [31:0] v,
                      input logic [3:0] sb, input logic [1:0] er);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        awaddr <= a;
        wdata <= v;
        wstrb <= sb;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd))
        begin
            @(posedge ref_clk);
            if (!ad && awready === 1'h1)
            begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (!wd && wready === 1'h1)
            begin
                wd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge ref_clk);
        chk(32'(bresp), 32'(er));
        bready <= 1'h0;
        @(posedge ref_clk);
    endtask
    // one read, answer compared with expectation
    task automatic rdr(input logic [4:0] a, input logic [31:0] ev,
                       input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        @(posedge ref_clk);
        while (arready !== 1'h1) @(posedge ref_clk);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge ref_clk);
        chk(rdata, ev);
        chk(32'(rresp), 32'(er));
        rready <= 1'h0;
        @(posedge ref_clk);
    endtask
    function automatic logic [31:0] tw();
        return {d[14:0], h[4:0], m[5:0], s[5:0]};
    endfunction
    // wait for k second ticks and advance the model alike
    task automatic tk(input int k);
        logic [31:0] lw;
        repeat (k)
        begin
            @(posedge ref_clk);
            while (wake_req !== 1'h1) @(posedge ref_clk);
            s++;
            st |= 1;
            if (s == 60)
            begin
                s = 0;
                m++;
                st |= 2;
            end
            if (m == 60)
            begin
                m = 0;
                h++;
                st |= 4;
            end
            if (h == 24)
            begin
                h = 0;
                d = (d + 1) % 32768;
                st |= 8;
            end
            // alarms latch status on the time after the tick, masked or not
            lw = tw();
            if (lw[16:0] == a0[16:0])
                st |= 16;
            if (lw == a1)
                st |= 32;
        end
    endtask
    // status read clears the model copy as well
    task automatic ckst(input int extra);
        rdr(`RTC_OFF_STATUS, 32'(st | extra), 2'h0);
        st = 0;
    endtask
    initial
    begin
        void'($urandom(32'h930B85EA));
        repeat (4) @(posedge ref_clk);
        nrst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        // reset values, status first, one unmapped place
        for (int i = 0; i < 8; i++)
            rdr(5'(((i + 5) % 8) * 4), 32'h0, i == 2 ? 2'h2 : 2'h0);
        rdr(5'h02, 32'h0, 2'h2);
        wr(5'h1C, 32'hFFFFFFFF, 4'hF, 2'h2);
        wr(`RTC_OFF_MASK, 32'h1, 4'hF, 2'h0);
        wr(`RTC_OFF_SWATCH, 32'h1234, 4'hF, 2'h0);
        wr(`RTC_OFF_SWATCH, 32'hAB00, 4'h2, 2'h0);
        rdr(`RTC_OFF_SWATCH, 32'hAB34, 2'h0);
        {s, m, h, d, st} = '0;
        wr(`RTC_OFF_TIME, tw(), 4'hF, 2'h0);
        // cascaded counting from random and boundary times
        for (int i = 0; i < 4; i++)
        begin
            tk(1);
            ckst(0);
            s = i ? 57 + $urandom % 3 : 59;
            m = (i == 0 || $urandom % 2) ? 59 : $urandom % 60;
            h = (i == 0 || $urandom % 2) ? 23 : $urandom % 24;
            d = i ? $urandom % 32768 : 32767;
            wr(`RTC_OFF_TIME, tw(), 4'hF, 2'h0);
            tk(1 + $urandom % 3);
            rdr(`RTC_OFF_TIME, tw(), 2'h0);
            chk(32'(irq), 32'h1);
            ckst(0);
            repeat (2) @(posedge ref_clk);
            chk(32'(irq), 32'h0);
        end
        // alarms: time of day only, then day and time
        tk(1);
        s = 30;
        m = 20;
        h = 10;
        d = 3;
        // alarm0 carries a foreign day that must be ignored
        a0 = {15'h9, h[4:0], m[5:0], 6'h20};
        a1 = {d[14:0], h[4:0], m[5:0], 6'h21};
        wr(`RTC_OFF_TIME, tw(), 4'hF, 2'h0);
        wr(`RTC_OFF_ALARM0, a0, 4'hF, 2'h0);
        wr(`RTC_OFF_ALARM1, a1, 4'hF, 2'h0);
        wr(`RTC_OFF_MASK, 32'h31, 4'hF, 2'h0);
        // a status write is ignored, the read shows only events
        wr(`RTC_OFF_STATUS, 32'h7F, 4'hF, 2'h0);
        ckst(0);
        for (int j = 0; j < 3; j++)
        begin
            tk(1);
            ckst(j == 1 ? 16 : j == 2 ? 32 : 0);
        end
        // stopwatch counts down and stops on underflow
        wr(`RTC_OFF_SWATCH, 32'h2, 4'hF, 2'h0);
        wr(`RTC_OFF_CTRL, 32'h1, 4'hF, 2'h0);
        wr(`RTC_OFF_MASK, 32'h41, 4'hF, 2'h0);
        ckst(0);
        tk(1);
        rdr(`RTC_OFF_SWATCH, 32'h1, 2'h0);
        tk(2);
        ckst(64);
        rdr(`RTC_OFF_CTRL, 32'h0, 2'h0);
        stop_test();
    end
endmodule
`default_nettype wire
